// [rscs_chk.sv]
// Port checker for the reset and slow clock switch
`timescale 1ns/10ps
`default_nettype none
module rscs_chk #(parameter MAL_CYCLES = 24)(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic watchdogReq,
  input wire logic ctlWrite,
  input wire logic [7:0] ctlWdata,
  input wire logic coreOnFast_r,
  input wire logic resetPinOut_r,
  input wire logic resetPinOe_r,
  input wire logic coreReset_r,
  input wire logic vectorRead_r,
  input wire logic vectorFetch_r,
  input wire logic [15:0] vectorAddr_r
);
  logic [7:0] oeCnt_r;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Length of the current pin drive, 8 bits so an overrun shows long before it wraps at 256
  always @(posedge clk or negedge arst_n)
    if (!arst_n)
      oeCnt_r <= 8'h00;
    else
      oeCnt_r <= resetPinOe_r ? oeCnt_r + 8'h01 : 8'h00;
  chk_pin_low: assert property (resetPinOe_r |-> !resetPinOut_r)
    else $error("pin driven high");
  chk_pin_cause: assert property (resetPinOe_r |-> coreReset_r)
    else $error("pin low without reset");
  chk_wdog_hit: assert property
    (watchdogReq && !coreReset_r |=> coreReset_r && resetPinOe_r)
    else $error("watchdog ignored");
  chk_fault_hit: assert property
    (ctlWrite && ctlWdata[7:6] == 2'h0 && !coreReset_r |=> coreReset_r)
    else $error("clock fault ignored");
  chk_drive_len: assert property (oeCnt_r <= MAL_CYCLES)
    else $error("pin held too long");
  chk_vec_order: assert property (vectorRead_r |=> vectorFetch_r)
    else $error("no fetch after vector");
  chk_vec_addr: assert property (vectorRead_r |-> vectorAddr_r == 16'hfffe)
    else $error("wrong vector");
  chk_fast_start: assert property ($fell(coreReset_r) |-> coreOnFast_r)
    else $error("not fast after reset");
  cover property ($rose(resetPinOe_r));
  cover property (vectorFetch_r);
  cover property ($rose(coreOnFast_r));
endmodule
bind rscs_reset_clock_switch rscs_chk #(.MAL_CYCLES(MAL_CYCLES)) rscs_chk_i (.*);
`default_nettype wire

// [rscs_defs.vh]
// Constants for the reset and slow clock switch block
`ifndef RSCS_DEFS_VH
`define RSCS_DEFS_VH
`define RSCS_SEL_BIT 5
`define RSCS_LOW_BIT 6
`define RSCS_FAST_BIT 7
`define RSCS_CTL_RESET 8'h80
`define RSCS_MAL_CYCLES 24
`define RSCS_EXT_CYCLES 12
`define RSCS_SYNC_CYCLES 2
`define RSCS_VECTOR_ADDR 16'hfffe
`define RSCS_WARM_MODE 8'h05
`define RSCS_WARM_SRC 8'h43
`endif

// [rscs_far_side.sv]
// Far side model: slow oscillator and the shared reset pin
`timescale 1ns/10ps
`default_nettype none
module rscs_far_side (
  input wire logic extLow,
  input wire logic resetPinOe_r,
  input wire logic resetPinOut_r,
  output logic resetPinIn,
  output logic lowClkTick
);
  // Pull-up holds the pin high unless someone drives it
  assign resetPinIn = resetPinOe_r ? resetPinOut_r : !extLow;
  // Low oscillator runs free, unrelated to the core clock
  initial
  begin
    lowClkTick = 1'b0;
    forever #43 lowClkTick = !lowClkTick;
  end
endmodule
`default_nettype wire

// [rscs_reset_clock_switch.v]
// Reset generator, clock mode switch and warm-up counter
`timescale 1ns/10ps
`default_nettype none
`include "rscs_defs.vh"
module rscs_reset_clock_switch #(
  parameter MAL_CYCLES = `RSCS_MAL_CYCLES,
  parameter EXT_CYCLES = `RSCS_EXT_CYCLES
)(
  input wire clk,
  input wire arst_n,
  input wire resetPinIn,
  input wire lowClkTick,
  input wire ctlWrite,
  input wire [7:0] ctlWdata,
  input wire watchdogReq,
  input wire fetchValid,
  input wire fetchSpecialRegion,
  input wire fetchBufferRegion,
  input wire fetchRam,
  input wire trapRamAreaSelect,
  input wire [7:0] warmCtlLower,
  input wire [7:0] warmCtlUpper,
  input wire warmRun,
  input wire [15:0] warmCount,
  output reg [7:0] systemControlTwo_r,
  output reg coreOnFast_r,
  output reg resetPinOut_r,
  output reg resetPinOe_r,
  output reg coreReset_r,
  output reg vectorRead_r,
  output reg vectorFetch_r,
  output reg [15:0] vectorAddr_r,
  output reg interruptMasterFlag_r,
  output reg [15:0] interruptEnableFlags_r,
  output reg timerPairInterrupt_r,
  output reg [1:0] clkMode_r
);
  // Mode codes reported on clkMode_r
  localparam MODE_FAST_SINGLE = 2'h0;
  localparam MODE_FAST_DUAL = 2'h1;
  localparam MODE_LOW_DUAL = 2'h2;
  localparam MODE_LOW_ONLY = 2'h3;

  // Release sequencing states
  localparam ST_RESET = 2'h0;
  localparam ST_VECTOR = 2'h1;
  localparam ST_FETCH = 2'h2;
  localparam ST_RUN = 2'h3;

  reg pinMeta_r;
  reg pinSync_r;
  reg tickMeta_r;
  reg tickSync_r;
  reg tickPrev_r;
  reg [4:0] extCnt_r;
  reg [4:0] malCnt_r;
  reg [1:0] syncCnt_r;
  reg [15:0] warmCnt_r;
  reg [1:0] state_r;
  reg [7:0] ctlNxt;
  reg clkFault;
  reg trapHit;
  wire malReq;
  wire extReset;
  wire anyReset;
  wire lowEdge;

  // Two-stage synchronisers for the pin and the low clock tick
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      // Pin idles high; a low reset value would fake a pin low
      pinMeta_r <= 1'b1;
      pinSync_r <= 1'b1;
      tickMeta_r <= 1'b0;
      tickSync_r <= 1'b0;
      tickPrev_r <= 1'b0;
    end
    else
    begin
      pinMeta_r <= resetPinIn;
      pinSync_r <= pinMeta_r;
      tickMeta_r <= lowClkTick;
      tickSync_r <= tickMeta_r;
      tickPrev_r <= tickSync_r;
    end
  end

  assign lowEdge = tickSync_r & ~tickPrev_r;

  // Detection of illegal oscillator shutdowns and trapped fetches
  always @*
  begin
    ctlNxt = ctlWdata;
    clkFault = 1'b0;
    trapHit = 1'b0;
    if (ctlWrite)
    begin
      if (!ctlNxt[`RSCS_FAST_BIT] && !ctlNxt[`RSCS_LOW_BIT])
        clkFault = 1'b1;
      if (!ctlNxt[`RSCS_FAST_BIT] && !systemControlTwo_r[`RSCS_SEL_BIT])
        clkFault = 1'b1;
      if (!ctlNxt[`RSCS_LOW_BIT] && systemControlTwo_r[`RSCS_SEL_BIT])
        clkFault = 1'b1;
    end
    if (fetchValid && (fetchSpecialRegion || fetchBufferRegion ||
        (fetchRam && trapRamAreaSelect)))
      trapHit = 1'b1;
  end

  // Malfunction sources: trap, watchdog, clock fault
  assign malReq = (trapHit | watchdogReq | clkFault) & ~coreReset_r;
  // Only a low held long enough counts as external reset
  assign extReset = (extCnt_r >= EXT_CYCLES[4:0]);
  assign anyReset = extReset | (malCnt_r != 5'h0) | malReq;

  // Pin low counter and malfunction pulse counter
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      extCnt_r <= 5'h0;
      malCnt_r <= 5'h0;
    end
    else
    begin
      if (pinSync_r)
        extCnt_r <= 5'h0;
      else if (extCnt_r < EXT_CYCLES[4:0])
        extCnt_r <= extCnt_r + 5'h1;
      // Request cycle counts as the first of the drive cycles
      if (malReq)
        malCnt_r <= MAL_CYCLES[4:0] - 5'h1;
      else if (malCnt_r != 5'h0)
        malCnt_r <= malCnt_r - 5'h1;
    end
  end

  // Reset output, pin drive and release sequence
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      coreReset_r <= 1'b1;
      resetPinOut_r <= 1'b0;
      resetPinOe_r <= 1'b0;
      state_r <= ST_RESET;
      vectorRead_r <= 1'b0;
      vectorFetch_r <= 1'b0;
      vectorAddr_r <= `RSCS_VECTOR_ADDR;
      interruptMasterFlag_r <= 1'b0;
      interruptEnableFlags_r <= 16'h0;
    end
    else
    begin
      resetPinOut_r <= 1'b0;
      // Pin is open drain: only drive for internal sources
      resetPinOe_r <= (malCnt_r != 5'h0) | malReq;
      vectorRead_r <= 1'b0;
      vectorFetch_r <= 1'b0;
      case (state_r)
        ST_RESET:
        begin
          coreReset_r <= 1'b1;
          if (!anyReset && pinSync_r)
            state_r <= ST_VECTOR;
        end
        ST_VECTOR:
        begin
          coreReset_r <= 1'b0;
          vectorRead_r <= 1'b1;
          vectorAddr_r <= `RSCS_VECTOR_ADDR;
          state_r <= ST_FETCH;
        end
        ST_FETCH:
        begin
          vectorFetch_r <= 1'b1;
          state_r <= ST_RUN;
        end
        ST_RUN:
        begin
          coreReset_r <= 1'b0;
        end
        default:
          state_r <= ST_RESET;
      endcase
      if (anyReset)
      begin
        state_r <= ST_RESET;
        coreReset_r <= 1'b1;
        // Only flags with defined defaults; core registers stay
        interruptMasterFlag_r <= 1'b0;
        interruptEnableFlags_r <= 16'h0;
      end
    end
  end

  // Control two register and clock switching
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      systemControlTwo_r <= `RSCS_CTL_RESET;
      coreOnFast_r <= 1'b1;
      syncCnt_r <= 2'h0;
      clkMode_r <= MODE_FAST_SINGLE;
    end
    else if (anyReset)
    begin
      // Any reset ends slow mode and restarts fast
      systemControlTwo_r <= `RSCS_CTL_RESET;
      coreOnFast_r <= 1'b1;
      syncCnt_r <= 2'h0;
      clkMode_r <= MODE_FAST_SINGLE;
    end
    else
    begin
      if (ctlWrite)
        systemControlTwo_r <= ctlWdata;
      // Fast oscillator left alone while slow
      if (systemControlTwo_r[`RSCS_SEL_BIT])
      begin
        syncCnt_r <= 2'h0;
        if (lowEdge)
          coreOnFast_r <= 1'b0;
      end
      else if (!coreOnFast_r)
      begin
        // Stay on low clock until edges line up
        if (lowEdge)
        begin
          if (syncCnt_r == `RSCS_SYNC_CYCLES - 1)
            coreOnFast_r <= 1'b1;
          else
            syncCnt_r <= syncCnt_r + 2'h1;
        end
      end
      if (coreOnFast_r)
        clkMode_r <= systemControlTwo_r[`RSCS_LOW_BIT] ?
          MODE_FAST_DUAL : MODE_FAST_SINGLE;
      else
        clkMode_r <= systemControlTwo_r[`RSCS_FAST_BIT] ?
          MODE_LOW_DUAL : MODE_LOW_ONLY;
    end
  end

  // Cascaded warm-up counter on the low clock
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      warmCnt_r <= 16'h0;
      timerPairInterrupt_r <= 1'b0;
    end
    else
    begin
      timerPairInterrupt_r <= 1'b0;
      if (!warmRun || warmCtlLower != `RSCS_WARM_SRC ||
          warmCtlUpper != `RSCS_WARM_MODE || anyReset)
        warmCnt_r <= 16'h0;
      else if (lowEdge)
      begin
        if (warmCnt_r == warmCount - 16'h1)
        begin
          warmCnt_r <= 16'h0;
          timerPairInterrupt_r <= 1'b1;
        end
        else
          warmCnt_r <= warmCnt_r + 16'h1;
      end
    end
  end
endmodule
`default_nettype wire

// [test_reset_and_slow_clock_switch.sv]
// Self-checking bench for the reset and slow clock switch
`timescale 1ns/10ps
`default_nettype none
`include "rscs_defs.vh"
module test_reset_and_slow_clock_switch;
  logic clk, arst_n, extLow, resetPinIn, lowClkTick, ctlWrite;
  logic watchdogReq, fetchValid, fetchSpecialRegion, fetchBufferRegion;
  logic fetchRam, trapRamAreaSelect, warmRun, coreOnFast_r, resetPinOut_r;
  logic resetPinOe_r, coreReset_r, vectorRead_r, vectorFetch_r;
  logic interruptMasterFlag_r, timerPairInterrupt_r;
  logic [7:0] ctlWdata, warmCtlLower, warmCtlUpper, systemControlTwo_r;
  logic [15:0] warmCount, vectorAddr_r, interruptEnableFlags_r;
  logic [1:0] clkMode_r;
  int fails, nCompared, k;
  rscs_reset_clock_switch rscs_reset_clock_switch_i (.*);
  rscs_far_side rscs_far_side_i (.*);
  task summarize;
    if (fails == 0 && nCompared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task cmp(input logic [15:0] got, input logic [15:0] exp);
    nCompared++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Inputs always change 1 ns after the edge
  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task bail(input int i);
    if (i >= 300)
    begin
      fails++;
      summarize;
    end
  endtask
  function logic sig(input int w);
    case (w)
      0: sig = coreOnFast_r;
      1: sig = timerPairInterrupt_r;
      default: sig = coreReset_r;
    endcase
  endfunction
  task waitSig(input int w, input logic v);
    int i;
    for (i = 0; i < 300 && sig(w) !== v; i++)
      step(1);
    bail(i);
    cmp(sig(w), v);
  endtask
  task wr(input logic [7:0] v);
    ctlWdata = v;
    ctlWrite = 1'b1;
    step(1);
    ctlWrite = 1'b0;
  endtask
  // Wait out a reset, then follow the vector sequence
  task hit(input int expOe);
    int i, oe;
    oe = 0;
    waitSig(2, 1'b1);
    for (i = 0; i < 300 && coreReset_r === 1'b1; i++)
    begin
      oe += resetPinOe_r;
      step(1);
    end
    bail(i);
    cmp(oe, expOe);
    cmp(vectorRead_r, 1'b1);
    cmp(vectorAddr_r, 16'hfffe);
    cmp(interruptMasterFlag_r, 1'b0);
    cmp(interruptEnableFlags_r, 16'h0000);
    cmp(systemControlTwo_r, `RSCS_CTL_RESET);
    cmp(coreOnFast_r, 1'b1);
    cmp(clkMode_r, 2'h0);
    step(1);
    cmp(vectorFetch_r, 1'b1);
    step(2);
  endtask
  initial
  begin
    clk = 1'b0;
    forever #5 clk = !clk;
  end
  initial
  begin
    {arst_n, extLow, ctlWrite, watchdogReq, fetchValid, warmRun} = 6'h00;
    {fetchSpecialRegion, fetchBufferRegion, fetchRam} = 3'h0;
    {trapRamAreaSelect, ctlWdata} = 9'h000;
    {warmCtlLower, warmCtlUpper, warmCount} = 32'h43050003;
    fails = 0;
    nCompared = 0;
    step(8);
    arst_n = 1'b1;
    hit(0);
    // Slow with the fast oscillator kept, then stopped
    wr(8'he0);
    waitSig(0, 1'b0);
    wr(8'h60);
    step(2);
    cmp(coreReset_r, 1'b0);
    cmp(clkMode_r, 2'h3);
    // Warm-up, then back to fast only after sync
    wr(8'he0);
    warmRun = 1'b1;
    waitSig(1, 1'b1);
    cmp(clkMode_r, 2'h2);
    warmRun = 1'b0;
    wr(8'hc0);
    cmp(coreOnFast_r, 1'b0);
    waitSig(0, 1'b1);
    // Short pin pulse ignored, long one ends slow mode
    wr(8'he0);
    waitSig(0, 1'b0);
    extLow = 1'b1;
    step(5);
    extLow = 1'b0;
    step(4);
    cmp(coreReset_r, 1'b0);
    extLow = 1'b1;
    step(20);
    extLow = 1'b0;
    hit(0);
    // Illegal oscillator stops, then a watchdog request
    wr(8'he0);
    waitSig(0, 1'b0);
    wr(8'ha0);
    hit(`RSCS_MAL_CYCLES);
    wr(8'h40);
    hit(`RSCS_MAL_CYCLES);
    wr(8'h00);
    hit(`RSCS_MAL_CYCLES);
    watchdogReq = 1'b1;
    step(1);
    watchdogReq = 1'b0;
    waitSig(2, 1'b1);
    cmp(resetPinOe_r, 1'b1);
    hit(`RSCS_MAL_CYCLES);
    // Trapped fetch regions, trap RAM area selected
    fetchValid = 1'b1;
    trapRamAreaSelect = 1'b1;
    for (k = 0; k < 3; k++)
    begin
      {fetchSpecialRegion, fetchBufferRegion, fetchRam} = 3'h4 >> k;
      step(1);
      {fetchSpecialRegion, fetchBufferRegion, fetchRam} = 3'h0;
      hit(`RSCS_MAL_CYCLES);
    end
    {fetchRam, trapRamAreaSelect} = 2'h2;
    step(3);
    cmp(coreReset_r, 1'b0);
    summarize;
  end
endmodule
`default_nettype wire
